// File: sensor_link_reader.sv
// two-line serial master that reads one 12-bit temperature from the external sensor
`timescale 1ns/1ps
module sensor_link_reader #(
	parameter logic [6:0] SENSOR_ADDR = 7'h48
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         start,
	output logic              done,
	output logic              error,
	output logic [11:0]       temp,
	input  wire logic         sensor_serial_clock_in,
	output logic              sensor_serial_clock_out,
	output logic              sensor_serial_clock_oe,
	input  wire logic         sensor_serial_data_in,
	output logic              sensor_serial_data_out,
	output logic              sensor_serial_data_oe
);
	import temp_wave_pkg::*;

	localparam logic [7:0] QMAX = 8'(QUARTER_CYCLES - 1);

	link_state_type state;
	logic [1:0]     scl_meta;
	logic [1:0]     sda_meta;
	logic [7:0]     qcnt;
	logic [1:0]     phase;
	logic [3:0]     bit_idx;
	logic [1:0]     byte_idx;
	logic [15:0]    shift;
	logic           tick;
	logic           stall;
	logic           tx_bit;

	// ==========================================================
	// pin synchronisers, second stage only is read
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_meta <= 2'h3;
			sda_meta <= 2'h3;
		end else begin
			scl_meta <= {scl_meta[0], sensor_serial_clock_in};
			sda_meta <= {sda_meta[0], sensor_serial_data_in};
		end
	end

	// sensor may stretch the clock: hold the high half until the line really rises
	assign stall = (state == LK_BITS) && phase[1] && !scl_meta[1];
	assign tick  = (qcnt == QMAX) && !stall;

	// ==========================================================
	// quarter-period timer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			qcnt <= 8'h00;
		end else if (state == LK_IDLE || tick) begin
			qcnt <= 8'h00;
		end else if (!stall) begin
			qcnt <= qcnt + 8'h01;
		end
	end

	// ==========================================================
	// transfer sequencer: start, address+read, two data bytes, stop
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= LK_IDLE;
			phase    <= 2'h0;
			bit_idx  <= 4'h0;
			byte_idx <= 2'h0;
			shift    <= 16'h0000;
			done     <= 1'b0;
			error    <= 1'b0;
			temp     <= TEMP_RESET;
		end else begin
			done <= 1'b0;
			unique case (state)
				LK_IDLE: begin
					phase    <= 2'h0;
					bit_idx  <= 4'h0;
					byte_idx <= 2'h0;
					if (start) begin
						error <= 1'b0;
						state <= LK_START;
					end
				end
				LK_START: begin
					if (tick) begin
						phase <= phase + 2'h1;
						if (phase == 2'h3)
							state <= LK_BITS;
					end
				end
				LK_BITS: begin
					if (tick) begin
						phase <= phase + 2'h1;
						if (phase == 2'h3) begin
							// sample at the end of the high half
							if (byte_idx == 2'h0 && bit_idx == ACK_SLOT && sda_meta[1])
								error <= 1'b1;
							if (byte_idx != 2'h0 && bit_idx != ACK_SLOT)
								shift <= {shift[14:0], sda_meta[1]};
							if (bit_idx == ACK_SLOT) begin
								bit_idx  <= 4'h0;
								byte_idx <= byte_idx + 2'h1;
								if (byte_idx == LAST_LINK_BYTE)
									state <= LK_STOP;
							end else begin
								bit_idx <= bit_idx + 4'h1;
							end
						end
					end
				end
				LK_STOP: begin
					if (tick) begin
						phase <= phase + 2'h1;
						if (phase == 2'h3) begin
							temp  <= shift[15:4];  // left-justified reading
							done  <= 1'b1;
							state <= LK_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// open-drain drive: enable high pulls the line low
	always_comb begin
		if (byte_idx == 2'h0)
			tx_bit = (bit_idx == ACK_SLOT) ? 1'b1 : (bit_idx[2:0] == 3'h7 ? 1'b1 : SENSOR_ADDR[3'h6 - bit_idx[2:0]]);
		else if (byte_idx == 2'h1)
			tx_bit = (bit_idx != ACK_SLOT);  // master ack after first data byte
		else
			tx_bit = 1'b1;                   // nack ends the read
	end

	always_comb begin
		sensor_serial_clock_oe = 1'b0;
		sensor_serial_data_oe  = 1'b0;
		unique case (state)
			LK_IDLE: begin
			end
			LK_START: begin
				sensor_serial_data_oe = phase[1];
			end
			LK_BITS: begin
				sensor_serial_clock_oe = !phase[1];
				sensor_serial_data_oe  = !tx_bit;
			end
			LK_STOP: begin
				sensor_serial_clock_oe = (phase == 2'h0);
				sensor_serial_data_oe  = !phase[1];
			end
		endcase
	end

	assign sensor_serial_clock_out = 1'b0;
	assign sensor_serial_data_out  = 1'b0;
endmodule

// File: temp_sensor_model.sv
// behavioural digital temperature sensor answering reads on the two-line link
`timescale 1ns/1ps
module temp_sensor_model #(
	parameter logic [6:0] ADDR = 7'h48
) (
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic [11:0] reading,
	input  wire logic        refuse,
	input  wire logic        stretch,
	output logic             scl_oe,
	output logic             sda_oe
);
	logic [7:0]  addr_byte;
	logic [15:0] word;
	// ==========================================================
	// slave sequence
	// never starts a transfer itself, only follows the master's start
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		forever begin
			@(negedge sda iff scl === 1'b1);
			for (int i = 0; i < 8; i++) begin
				@(posedge scl);
				addr_byte = {addr_byte[6:0], sda};
			end
			@(negedge scl);
			// stays silent on a foreign address or when told to refuse
			if (addr_byte === {ADDR, 1'b1} && !refuse) begin
				#1000 sda_oe = 1'b1;
				@(negedge scl);
				#1000;
				word = {reading, 4'h5};
				for (int k = 0; k < 2; k++) begin
					for (int b = 0; b < 8; b++) begin
						sda_oe = ~word[15 - 8 * k - b];
						// slow answer: hold the clock low well past the master's low half
						if (stretch && k == 0 && b == 0) begin
							scl_oe = 1'b1;
							#20000 scl_oe = 1'b0;
						end
						@(negedge scl);
						#1000;
					end
					sda_oe = 1'b0; // released for the master's ack or nack
					@(negedge scl);
					#1000;
				end
			end
		end
	end
endmodule

// File: temp_wave_pkg.sv
// shared constants and state codes for the temperature driven waveform selector
package temp_wave_pkg;
	// ==========================================================
	// store layout
	localparam int          SET_COUNT       = 25;
	localparam int          SET_BYTES       = 76;
	localparam int          LUT_BYTES       = 70;
	localparam int          LUT_BITS        = 560;
	localparam int          RANGE_BYTES     = 3;
	localparam int          ADDR_W          = 11;
	localparam int          TEMP_W          = 12;
	localparam int          IDX_W           = 5;
	localparam int          BYTE_W          = 7;
	localparam logic [10:0] SET_BASE        = 11'h000;
	localparam logic [10:0] LAST_SET_BYTE   = 11'h76b;  // 1899
	localparam logic [10:0] RANGE_BASE      = 11'h76c;  // 1900
	localparam logic [10:0] LAST_RANGE_BYTE = 11'h7b6;  // 1974
	localparam logic [4:0]  LAST_SET        = 5'h18;    // 24
	localparam logic [6:0]  GATE_LEVEL_BYTE = 7'h46;    // 70
	localparam logic [6:0]  SRC_FIRST_BYTE  = 7'h47;    // 71
	localparam logic [6:0]  SRC_LAST_BYTE   = 7'h49;    // 73
	localparam logic [6:0]  DUMMY_BYTE      = 7'h4a;    // 74
	localparam logic [6:0]  LINE_WIDTH_BYTE = 7'h4b;    // 75
	localparam logic [1:0]  REC_LOW_BYTE    = 2'h0;
	localparam logic [1:0]  REC_MID_BYTE    = 2'h1;
	localparam logic [1:0]  REC_HIGH_BYTE   = 2'h2;
	localparam logic [11:0] TEMP_RESET      = 12'h000;
	localparam int          TEMP_SIGN_BIT   = 11;
	// ==========================================================
	// sensor link timing
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          SCL_PERIOD_NS   = 10000;
	localparam int          QUARTER_CYCLES  = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  ACK_SLOT        = 4'h8;
	localparam logic [1:0]  LAST_LINK_BYTE  = 2'h2;
	// ==========================================================
	// state codes
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_SENSE  = 5'b00010,
		ST_SCAN   = 5'b00100,
		ST_LOAD   = 5'b01000,
		ST_FINISH = 5'b10000
	} sel_state_type;
	typedef enum logic [3:0] {
		LK_IDLE  = 4'b0001,
		LK_START = 4'b0010,
		LK_BITS  = 4'b0100,
		LK_STOP  = 4'b1000
	} link_state_type;
endpackage

// File: temp_waveform_selector.sv
// temperature search over the stored range records and load of the matching waveform set
//
// Functional notes
// - store holds 25 waveform sets, 25 range records, common voltage and version id
// - set m chosen when lower limit < temperature <= upper limit
// - set m starts at byte m*76; last set ends at byte 1899
// - range records from byte 1900: lower[7:0], upper[3:0]|lower[11:8], upper[11:4]
// - selected waveform lands in a volatile 560-bit lookup register
// - temperature used by the search sits in a volatile 12-bit register
// - records compared first to last; last match wins
// - records may be in any order
// - pointer holds the index of the selected waveform set
// - bit 11 clear: positive, degrees = value/16
// - bit 11 set: negative, magnitude = two's complement/16
// - limits compared as signed 12-bit; 800 lowest, 7ff highest
// - block is sole master on the sensor link
// - set is 76 bytes: 70 lookup, gate, three source, dummy, line width
`timescale 1ns/1ps
module temp_waveform_selector #(
	parameter logic [6:0] SENSOR_ADDR = 7'h48
) (
	input  wire logic                         sys_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         search_start,
	input  wire logic                         use_external_sensor,
	input  wire logic [temp_wave_pkg::TEMP_W-1:0] internal_temp,
	output logic [temp_wave_pkg::ADDR_W-1:0]  store_addr,
	output logic                              store_rd,
	input  wire logic [7:0]                   store_data,
	input  wire logic                         sensor_serial_clock_in,
	output logic                              sensor_serial_clock_out,
	output logic                              sensor_serial_clock_oe,
	input  wire logic                         sensor_serial_data_in,
	output logic                              sensor_serial_data_out,
	output logic                              sensor_serial_data_oe,
	output logic [temp_wave_pkg::LUT_BITS-1:0] lookup,
	output logic [7:0]                        gate_level,
	output logic [23:0]                       source_levels,
	output logic [7:0]                        dummy_line,
	output logic [7:0]                        gate_line_width,
	output logic [temp_wave_pkg::IDX_W-1:0]   selected_set_pointer,
	output logic                              set_valid,
	output logic [temp_wave_pkg::TEMP_W-1:0]  temperature,
	output logic                              temp_negative,
	output logic                              busy,
	output logic                              done,
	output logic                              no_match,
	output logic                              sensor_error
);
	import temp_wave_pkg::*;

	sel_state_type      state;
	logic               rd_wait;
	logic [IDX_W-1:0]   rec_idx;
	logic [BYTE_W-1:0]  byte_idx;
	logic [11:0]        lo_lim;
	logic [3:0]         hi_nib;
	logic [IDX_W-1:0]   best_idx;
	logic               best_hit;
	logic               hit;
	logic               link_start;
	logic               link_done;
	logic               link_err;
	logic [11:0]        link_temp;

	// ==========================================================
	// address and compare helpers
	function automatic logic [10:0] set_addr(input logic [4:0] idx, input logic [6:0] b);
		set_addr = 11'(SET_BASE + idx * SET_BYTES + b);
	endfunction

	function automatic logic [10:0] range_addr(input logic [4:0] idx, input logic [6:0] b);
		range_addr = 11'(RANGE_BASE + idx * RANGE_BYTES + b);
	endfunction

	// signed view makes 800 the floor and 7ff the ceiling
	function automatic logic in_range(input logic [11:0] t, input logic [11:0] lo, input logic [11:0] hi);
		in_range = ($signed(t) > $signed(lo)) && ($signed(t) <= $signed(hi));
	endfunction

	// ==========================================================
	// sensor link
	sensor_link_reader #(
		.SENSOR_ADDR (SENSOR_ADDR)
	) u_link (
		.sys_clk                 (sys_clk),
		.sys_rst                 (sys_rst),
		.start                   (link_start),
		.done                    (link_done),
		.error                   (link_err),
		.temp                    (link_temp),
		.sensor_serial_clock_in  (sensor_serial_clock_in),
		.sensor_serial_clock_out (sensor_serial_clock_out),
		.sensor_serial_clock_oe  (sensor_serial_clock_oe),
		.sensor_serial_data_in   (sensor_serial_data_in),
		.sensor_serial_data_out  (sensor_serial_data_out),
		.sensor_serial_data_oe   (sensor_serial_data_oe)
	);

	// ==========================================================
	// handshake and store strobes
	assign link_start    = (state == ST_IDLE) && search_start && use_external_sensor;
	assign busy          = (state != ST_IDLE);
	assign done          = (state == ST_FINISH);
	assign store_rd      = ((state == ST_SCAN) || (state == ST_LOAD)) && !rd_wait;
	assign store_addr    = (state == ST_LOAD) ? set_addr(best_idx, byte_idx) : range_addr(rec_idx, byte_idx);
	assign temp_negative = temperature[TEMP_SIGN_BIT];
	assign hit           = in_range(temperature, lo_lim, {store_data, hi_nib});

	// one-cycle store latency: every read waits one cycle for its byte
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			rd_wait <= 1'b0;
		else
			rd_wait <= store_rd;
	end

	// ==========================================================
	// temperature capture
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			temperature  <= TEMP_RESET;
			sensor_error <= 1'b0;
		end else if (state == ST_IDLE && search_start) begin
			if (!use_external_sensor)
				temperature <= internal_temp;
			sensor_error <= 1'b0;
		end else if (state == ST_SENSE && link_done) begin
			if (link_err)
				sensor_error <= 1'b1;
			else
				temperature <= link_temp;
		end
	end

	// ==========================================================
	// sequencer: sense, scan all records, then load the winner
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= ST_IDLE;
			rec_idx  <= 5'h00;
			byte_idx <= 7'h00;
			lo_lim   <= 12'h000;
			hi_nib   <= 4'h0;
			best_idx <= 5'h00;
			best_hit <= 1'b0;
			no_match <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					rec_idx  <= 5'h00;
					byte_idx <= 7'h00;
					best_hit <= 1'b0;
					if (search_start)
						state <= use_external_sensor ? ST_SENSE : ST_SCAN;
				end
				ST_SENSE: begin
					// a failed read selects nothing new
					if (link_done) begin
						no_match <= link_err;
						state    <= link_err ? ST_FINISH : ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (rd_wait) begin
						unique case (byte_idx[1:0])
							REC_LOW_BYTE: lo_lim[7:0] <= store_data;
							REC_MID_BYTE: begin
								lo_lim[11:8] <= store_data[3:0];
								hi_nib       <= store_data[7:4];
							end
							REC_HIGH_BYTE: begin
							end
							default: begin
							end
						endcase
						if (byte_idx[1:0] == REC_HIGH_BYTE) begin
							byte_idx <= 7'h00;
							// later records overwrite earlier ones; order of limits is irrelevant
							if (hit) begin
								best_idx <= rec_idx;
								best_hit <= 1'b1;
							end
							if (rec_idx == LAST_SET) begin
								no_match <= !(best_hit || hit);
								state    <= (best_hit || hit) ? ST_LOAD : ST_FINISH;
							end else begin
								rec_idx <= rec_idx + 5'h01;
							end
						end else begin
							byte_idx <= byte_idx + 7'h01;
						end
					end
				end
				ST_LOAD: begin
					if (rd_wait) begin
						byte_idx <= byte_idx + 7'h01;
						if (byte_idx == LINE_WIDTH_BYTE)
							state <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// waveform destination registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lookup          <= '0;
			gate_level      <= 8'h00;
			source_levels   <= 24'h000000;
			dummy_line      <= 8'h00;
			gate_line_width <= 8'h00;
		end else if (state == ST_LOAD && rd_wait) begin
			if (byte_idx < GATE_LEVEL_BYTE)
				lookup[8 * byte_idx +: 8] <= store_data;
			else if (byte_idx == GATE_LEVEL_BYTE)
				gate_level <= store_data;
			else if (byte_idx <= SRC_LAST_BYTE)
				source_levels <= {source_levels[15:0], store_data};
			else if (byte_idx == DUMMY_BYTE)
				dummy_line <= store_data;
			else
				gate_line_width <= store_data;
		end
	end

	// pointer moves only once the whole set has been loaded
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			selected_set_pointer <= 5'h00;
			set_valid            <= 1'b0;
		end else if (state == ST_LOAD && rd_wait && byte_idx == LINE_WIDTH_BYTE) begin
			selected_set_pointer <= best_idx;
			set_valid            <= 1'b1;
		end
	end

	// ==========================================================
	// checks
	a_ptr_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
		set_valid |-> selected_set_pointer <= LAST_SET)
		else $error("selected pointer beyond last set");

	a_load_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(store_rd && state == ST_LOAD) |-> store_addr == 11'(best_idx * SET_BYTES + byte_idx) && store_addr <= LAST_SET_BYTE)
		else $error("waveform read outside its set");

	a_scan_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(store_rd && state == ST_SCAN) |-> store_addr >= RANGE_BASE && store_addr <= LAST_RANGE_BYTE)
		else $error("range read outside record area");

	a_last_match: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_SCAN && rd_wait && byte_idx[1:0] == REC_HIGH_BYTE && hit)
		|=> best_hit && best_idx == $past(rec_idx))
		else $error("matching record not recorded");

	a_no_match_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(done && no_match) |-> $stable(selected_set_pointer) && $stable(lookup))
		else $error("selection changed without a match");

	a_temp_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_SCAN || state == ST_LOAD) |=> $stable(temperature))
		else $error("temperature changed during search");

	a_lut_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state != ST_LOAD) |=> $stable(lookup))
		else $error("lookup changed outside load");

	a_load_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(state == ST_LOAD) |-> ##152 done)
		else $error("waveform load not 76 bytes long");

	a_sign_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_IDLE && search_start && !use_external_sensor)
		|=> temp_negative == $past(internal_temp[TEMP_SIGN_BIT]))
		else $error("sign flag disagrees with reading");

	c_match: cover property (@(posedge sys_clk) disable iff (sys_rst) done && set_valid && !no_match);
	c_nomatch: cover property (@(posedge sys_clk) disable iff (sys_rst) done && no_match);
	c_external: cover property (@(posedge sys_clk) disable iff (sys_rst) state == ST_SENSE && link_done && !link_err);
	c_overlap: cover property (@(posedge sys_clk) disable iff (sys_rst)
		state == ST_SCAN && rd_wait && byte_idx[1:0] == REC_HIGH_BYTE && hit && best_hit);
endmodule

// File: testbench.sv
// self-checking bench for the temperature driven waveform selector
`timescale 1ns/1ps
module testbench;
	import temp_wave_pkg::*;
	logic                sys_clk, sys_rst, search_start, use_external_sensor, refuse, stretch, store_rd;
	logic                scl_oe_d, sda_oe_d, scl_oe_m, sda_oe_m;
	logic                set_valid, temp_negative, busy, done, no_match, sensor_error;
	logic [11:0]         internal_temp, reading, temperature;
	logic [10:0]         store_addr;
	logic [7:0]          store_data, gate_level, dummy_line, gate_line_width;
	logic [23:0]         source_levels;
	logic [LUT_BITS-1:0] lookup;
	logic [4:0]          selected_set_pointer;
	logic [7:0]          mem [0:1974];
	int                  error_cnt = 0;
	int                  samples_checked = 0;
	int                  cycles = 0;
	// open-drain lines with pull-ups
	wire                 scl = ~(scl_oe_d | scl_oe_m);
	wire                 sda = ~(sda_oe_d | sda_oe_m);

	temp_waveform_selector dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .search_start(search_start),
		.use_external_sensor(use_external_sensor), .internal_temp(internal_temp), .store_addr(store_addr),
		.store_rd(store_rd), .store_data(store_data), .sensor_serial_clock_in(scl), .sensor_serial_clock_out(),
		.sensor_serial_clock_oe(scl_oe_d), .sensor_serial_data_in(sda), .sensor_serial_data_out(),
		.sensor_serial_data_oe(sda_oe_d), .lookup(lookup), .gate_level(gate_level), .source_levels(source_levels),
		.dummy_line(dummy_line), .gate_line_width(gate_line_width), .selected_set_pointer(selected_set_pointer),
		.set_valid(set_valid), .temperature(temperature), .temp_negative(temp_negative), .busy(busy), .done(done),
		.no_match(no_match), .sensor_error(sensor_error));
	temp_sensor_model sensor (.scl(scl), .sda(sda), .reading(reading), .refuse(refuse), .stretch(stretch),
		.scl_oe(scl_oe_m), .sda_oe(sda_oe_m));

	// ==========================================================
	// clock, store with one cycle latency, hang guard
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (store_rd) store_data <= mem[store_addr];
	end
	// ceiling well above the three external reads plus thirteen scans
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			$display("ERROR %0t run did not finish", $time);
			wrap_up();
		end
	end
	// ==========================================================
	// helpers
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic set_range(input int i, input logic [11:0] lo, input logic [11:0] hi);
		mem[1900 + 3 * i] = lo[7:0];
		mem[1901 + 3 * i] = {hi[3:0], lo[11:8]};
		mem[1902 + 3 * i] = hi[11:4];
	endtask
	// zero limits on both ends never match, since the lower bound is strict
	task automatic clear_ranges;
		for (int a = 1900; a < 1975; a++) mem[a] = 8'h00;
	endtask
	task automatic search(input logic ext, input logic [11:0] t);
		int n;
		n = 0;
		@(negedge sys_clk);
		search_start = 1'b1;
		use_external_sensor = ext;
		internal_temp = t;
		@(negedge sys_clk);
		search_start = 1'b0;
		cmp(24'(busy), 24'h1, "busy");
		while (done !== 1'b1 && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		cmp(24'(n < 20000), 24'h1, "search end");
	endtask
	task automatic expect_set(input int m, input logic [11:0] t);
		int base;
		base = m * 76;
		cmp(24'(selected_set_pointer), 24'(m), "pointer");
		cmp(24'({set_valid, no_match}), 24'h2, "flags");
		cmp(24'(temperature), 24'(t), "temperature");
		cmp(24'(temp_negative), 24'(t[11]), "sign");
		for (int b = 0; b < 70; b++) cmp(24'(lookup[8 * b +: 8]), 24'(mem[base + b]), "lookup");
		cmp(24'(gate_level), 24'(mem[base + 70]), "gate level");
		cmp(source_levels, {mem[base + 71], mem[base + 72], mem[base + 73]}, "source levels");
		cmp({8'h00, dummy_line, gate_line_width}, {8'h00, mem[base + 74], mem[base + 75]}, "tail");
	endtask
	task automatic expect_none(input int m);
		cmp(24'(selected_set_pointer), 24'(m), "pointer kept");
		cmp(24'(no_match), 24'h1, "no match");
		cmp(24'(lookup[7:0]), 24'(mem[m * 76]), "lookup kept");
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		cmp(24'({selected_set_pointer, set_valid, busy, done, scl_oe_d, sda_oe_d}), 24'h0, "reset");
	endtask
	task automatic t_example;
		logic [11:0] lo [8] = '{12'h800, 12'h050, 12'h0a0, 12'h0f0, 12'h140, 12'h190, 12'h1e0, 12'h230};
		logic [11:0] hi [8] = '{12'h050, 12'h0a0, 12'h0f0, 12'h140, 12'h190, 12'h1e0, 12'h230, 12'h7ff};
		logic [11:0] t [4] = '{12'h050, 12'h170, 12'h7f0, 12'h0a1};
		int          want [4] = '{0, 4, 7, 2};
		clear_ranges();
		for (int i = 0; i < 8; i++) set_range(i, lo[i], hi[i]);
		for (int i = 0; i < 4; i++) begin
			search(1'b0, t[i]);
			expect_set(want[i], t[i]);
		end
	endtask
	task automatic t_overlap;
		clear_ranges();
		set_range(3, 12'h000, 12'h100);
		set_range(5, 12'h0f0, 12'h140);
		set_range(24, 12'h100, 12'h200);
		set_range(2, 12'h150, 12'h300);
		search(1'b0, 12'h0f8);
		expect_set(5, 12'h0f8);
		search(1'b0, 12'h180);
		expect_set(24, 12'h180);
		search(1'b0, 12'h250);
		expect_set(2, 12'h250);
	endtask
	task automatic t_negative;
		clear_ranges();
		set_range(0, 12'h800, 12'he70);
		set_range(1, 12'h050, 12'h0a0);
		search(1'b0, 12'he70);
		expect_set(0, 12'he70);
		search(1'b0, 12'he71);
		expect_none(0);
		search(1'b0, 12'h050);
		expect_none(0);
		search(1'b0, 12'h800);
		expect_none(0);
	endtask
	task automatic t_external;
		clear_ranges();
		set_range(6, 12'h180, 12'h190);
		set_range(7, 12'h190, 12'h7ff);
		reading = 12'h185;
		search(1'b1, 12'h000);
		expect_set(6, 12'h185);
		reading = 12'h191;
		stretch = 1'b1;
		search(1'b1, 12'h000);
		expect_set(7, 12'h191);
		cmp(24'(sensor_error), 24'h0, "sensor ok");
		refuse = 1'b1;
		search(1'b1, 12'h000);
		cmp(24'(sensor_error), 24'h1, "sensor refused");
		expect_none(7);
	endtask
	// ==========================================================
	// ending
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial begin
		sys_rst = 1'b1;
		search_start = 1'b0;
		use_external_sensor = 1'b0;
		internal_temp = 12'h000;
		reading = 12'h000;
		refuse = 1'b0;
		stretch = 1'b0;
		// bytes differ from set to set so a wrong base address shows
		for (int a = 0; a < 1900; a++) mem[a] = 8'(a * 7 + a / 76 + 1);
		clear_ranges();
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		t_reset();
		t_example();
		t_overlap();
		t_negative();
		t_external();
		wrap_up();
	end
endmodule
